// file: rtl/pddr_responder.v
// periodic data and background diagnostic command responder
`timescale 1ns/1ps
`default_nettype none
`include "pddr_defines.vh"
module pddr_responder #(
    parameter        DATA_W    = 10,     // sensor data field width
    parameter [9:0]  ERR_CODE  = 10'h3FF, // data replaced under fault
    parameter [7:0]  CMD_SEED  = 8'hFF,  // seed for diagnostic command check
    parameter [7:0]  CMD_POLY  = 8'h2F   // polynomial for command check
) (
    input  wire        CLOCK,            // core clock, 10 MHz
    input  wire        NRST,             // asynchronous reset, active low
    input  wire        PSEL,             // apb select
    input  wire        PENABLE,          // apb access phase
    input  wire        PWRITE,           // apb direction
    input  wire [11:0] PADDR,            // apb byte address
    input  wire [31:0] PWDATA,           // apb write data
    output reg  [31:0] PRDATA,           // apb read data
    output reg         PREADY,           // apb transfer done
    output reg         PSLVERR,          // apb unmapped address
    input  wire        CMD_VALID,        // one cycle: decoded command ready
    input  wire [5:0]  CMD_LEN,          // command length in bits
    input  wire [31:0] CMD_BITS,         // command bits, last in bit 0
    input  wire        CMD_SLOT,         // source slot of this command
    input  wire [DATA_W-1:0] MEAS_MAIN,  // measurement for data type 0
    input  wire [DATA_W-1:0] MEAS_AUX,   // measurement for data type 1
    input  wire        USER_UNLOCKED,    // user array not locked
    input  wire        SELFTEST_INCOMPLETE, // self test not done
    input  wire        SELFTEST_RUNNING, // self test active
    input  wire        SELFTEST_FAIL,    // self test failed
    input  wire        OSC_TRAIN_ERR,    // oscillator training error
    input  wire        SIGNAL_CLIPPED,   // signal clip
    input  wire        OFFSET_ERR,       // offset error
    input  wire        TEMP_ERR,         // temperature error
    output reg         RESP_STB,         // one cycle: periodic frame ready
    output reg  [5:0]  RESP_LEN,         // frame length in bits
    output reg  [31:0] RESP_FRAME,       // frame, last bit in bit 0
    output reg         DIAG_STB,         // one cycle: valid 32 bit command
    output reg         DIAG_ERR,         // one cycle: bad 32 bit command
    output reg  [31:0] DIAG_WORD,        // last good assembled command
    output reg         ENABLED           // periodic mode running
);
    // ==========================================================
    // register map, one aligned word each
    //   0x00 lock: bit 0 end of init, set only, reset clears it
    //   0x04 timing: bit 0 diagnostic enable, bit 1 fragment size
    //        (0 gives 2 bit, 1 gives 4 bit fragments)
    //   0x08 slot 0 and 0x0C slot 1 source settings:
    //        [3:0] identifier, [6:4] frame format, [8] data type
    //   0x10 physical address matched by diagnostic commands
    //   0x14 read only: [3:0] status code, [5:4] slot 0 counter,
    //        [7:6] slot 1 counter, [13:8] bits assembled
    //   0x18 read only: last good diagnostic command
    //   other offsets: slave error, reads give zero
    //   writes to read only words are dropped without error
    //
    // command side: a line decoder ahead of this block hands over
    //   one command per strobe with its length and bits, the last
    //   received bit in bit 0; the slot picks the source whose
    //   settings and counter the answer uses
    // limitation: two source slots only
    // ==========================================================
    // register state
    reg        end_of_init_flag;          // device_lock_write_reg
    reg [1:0]  timing_config_two_reg;
    reg [8:0]  per_source_id_reg0;
    reg [8:0]  per_source_id_reg1;
    reg [3:0]  phys_addr;
    reg [1:0]  keep_alive_count0;
    reg [1:0]  keep_alive_count1;
    reg [31:0] asm_word;                  // diagnostic assembly
    reg [5:0]  asm_cnt;                   // bits assembled so far

    // timing settings
    wire diag_en = timing_config_two_reg[`PDDR_TIM_DIAG_BIT];
    wire diag_fragment_size_sel = timing_config_two_reg[`PDDR_TIM_FRAG_BIT];
    wire [5:0] frag_len = diag_fragment_size_sel ? `PDDR_LEN_FRAG4 : `PDDR_LEN_FRAG2;

    // ==========================================================
    // apb decode
    //   one wait state: the access edge stores a write or loads
    //   read data, ready follows and drops again a cycle later
    //   ready gates the access term, so each access acts once
    wire apb_access = PSEL & PENABLE & ~PREADY;
    wire apb_wr     = apb_access & PWRITE;
    reg         addr_hit;
    reg  [31:0] rd_mux;
    reg  [3:0]  status_code;

    // read mux and address decode
    //   unmapped reads return zero along with the slave error
    always @* begin
        addr_hit = 1'b1;
        rd_mux   = 32'h00000000;
        case (PADDR)
            `PDDR_OFS_LOCK:    rd_mux = {31'h00000000, end_of_init_flag};
            `PDDR_OFS_TIMING2: rd_mux = {30'h00000000, timing_config_two_reg};
            `PDDR_OFS_SRC0:    rd_mux = {23'h000000, per_source_id_reg0};
            `PDDR_OFS_SRC1:    rd_mux = {23'h000000, per_source_id_reg1};
            `PDDR_OFS_PHYS:    rd_mux = {28'h0000000, phys_addr};
            `PDDR_OFS_STATUS:  rd_mux = {18'h00000, asm_cnt, keep_alive_count1,
                                         keep_alive_count0, status_code};
            `PDDR_OFS_DIAGCMD: rd_mux = DIAG_WORD;
            default:           addr_hit = 1'b0;
        endcase
    end

    // one wait state answer, error on unmapped address
    //   read data holds until the next read
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= apb_access;
            PSLVERR <= apb_access & ~addr_hit;
            if (apb_access && !PWRITE)
                PRDATA <= rd_mux;
        end
    end

    // register writes; end of init only sets, reset clears it
    //   software cannot clear end of init, so periodic mode stays
    //   on once started
    //   bit 7 of a source word is stored but has no use
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            end_of_init_flag      <= 1'b0;
            timing_config_two_reg <= `PDDR_RST_TIMING2;
            per_source_id_reg0    <= `PDDR_RST_SRC;
            per_source_id_reg1    <= `PDDR_RST_SRC;
            phys_addr             <= `PDDR_RST_PHYS;
        end else if (apb_wr) begin
            case (PADDR)
                `PDDR_OFS_LOCK:
                    if (PWDATA[`PDDR_LOCK_EOI_BIT])
                        end_of_init_flag <= 1'b1;
                `PDDR_OFS_TIMING2: timing_config_two_reg <= PWDATA[1:0];
                `PDDR_OFS_SRC0:    per_source_id_reg0 <= PWDATA[8:0];
                `PDDR_OFS_SRC1:    per_source_id_reg1 <= PWDATA[8:0];
                `PDDR_OFS_PHYS:    phys_addr <= PWDATA[3:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // status code, smallest priority number wins
    //   numbers: temperature 11, clip or offset 12, oscillator 13,
    //   self test 14, unlocked 15, normal 16
    //   several flags can share one code, as the self test ones do
    //   codes 6 and 7 are reserved and never produced
    always @* begin
        if (TEMP_ERR)
            status_code = `PDDR_ST_TEMP;
        else if (SIGNAL_CLIPPED || OFFSET_ERR)
            status_code = `PDDR_ST_CLIP;
        else if (OSC_TRAIN_ERR)
            status_code = `PDDR_ST_OSC;
        else if (SELFTEST_INCOMPLETE || SELFTEST_RUNNING || SELFTEST_FAIL)
            status_code = `PDDR_ST_SELFTEST;
        else if (USER_UNLOCKED)
            status_code = `PDDR_ST_UNLOCKED;
        else
            status_code = `PDDR_ST_NORMAL;
    end

    // ==========================================================
    // command classification
    //   length 1: broadcast read, answered without any check
    //   length equal to the fragment size, diagnostics on: fragment
    //   other lengths get no frame; a 2 or 4 of the wrong size
    //   keeps the assembly, any other length drops it
    //   nothing is taken before end of init has been written
    wire is_bcast  = CMD_LEN == `PDDR_LEN_BCAST;
    wire is_frag   = diag_en && (CMD_LEN == frag_len);
    wire len_other = (CMD_LEN != `PDDR_LEN_FRAG2) && (CMD_LEN != `PDDR_LEN_FRAG4);
    wire cmd_take  = end_of_init_flag & CMD_VALID;
    wire do_resp   = cmd_take & (is_bcast | is_frag);
    wire do_clear  = cmd_take & (is_bcast | len_other);

    // next assembly word and count
    //   fragments enter msb first, so the first one ends in bit 31
    //   hazard: changing the fragment size mid command keeps the
    //   partial word; disable diagnostics first to drop it
    wire [31:0] next_asm = diag_fragment_size_sel ? {asm_word[27:0], CMD_BITS[3:0]}
                                                  : {asm_word[29:0], CMD_BITS[1:0]};
    wire [5:0]  next_cnt = asm_cnt + frag_len;
    wire        asm_full = cmd_take & is_frag & (next_cnt == `PDDR_DIAG_BITS);

    // command mode check of the assembled word: address and check value
    //   address must be this device's or the global one, and the
    //   last eight bits must match the check over the 24 before
    wire [7:0] cmd_crc;
    pddr_crc8 #(
        .POLY (CMD_POLY)
    ) u_cmd_crc (
        .seed (CMD_SEED),
        .msg  ({8'h00, next_asm[31:8]}),
        .len  (6'h18),
        .crc  (cmd_crc)
    );
    // accepted addresses
    wire addr_ok = (next_asm[31:28] == phys_addr) ||
                   (next_asm[31:28] == `PDDR_GLOBAL_ADDR);
    wire cmd_ok  = addr_ok && (cmd_crc == next_asm[7:0]);

    // diagnostic assembly
    //   a good word is held and strobed, a bad one only strobes the
    //   error; assembly restarts either way, and turning
    //   diagnostics off drops a partial word
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            asm_word  <= 32'h00000000;
            asm_cnt   <= 6'h00;
            DIAG_STB  <= 1'b0;
            DIAG_ERR  <= 1'b0;
            DIAG_WORD <= 32'h00000000;
        end else begin
            DIAG_STB <= asm_full & cmd_ok;
            DIAG_ERR <= asm_full & ~cmd_ok;
            if (asm_full && cmd_ok)
                DIAG_WORD <= next_asm;
            if (do_clear || asm_full || !diag_en) begin
                asm_word <= 32'h00000000;
                asm_cnt  <= 6'h00;
            end else if (cmd_take && is_frag) begin
                asm_word <= next_asm;
                asm_cnt  <= next_cnt;
            end
        end
    end

    // ==========================================================
    // frame assembly for the addressed source
    //   first sent bit leftmost, right aligned in the word:
    //   [id 4] [keep alive 2] [status 4] [data DATA_W] [check 8]
    //   format bit 0 adds the id, bit 1 the counter, bit 2 status
    //   frames run from 18 to 28 bits with the default data width
    wire [8:0] src_reg = CMD_SLOT ? per_source_id_reg1 : per_source_id_reg0;
    wire [3:0] src_id  = src_reg[`PDDR_SRC_ID_LSB +: `PDDR_ID_W];
    wire [2:0] periodic_frame_format = src_reg[`PDDR_SRC_FMT_LSB +: 3];
    wire       data_type_select = src_reg[`PDDR_SRC_DTYPE_BIT];
    wire [1:0] kac_cur = CMD_SLOT ? keep_alive_count1 : keep_alive_count0;
    wire       stat_on = periodic_frame_format[`PDDR_FMT_STAT_BIT];

    // frame body under construction
    reg  [31:0] body;
    reg  [5:0]  body_len;
    reg  [DATA_W-1:0] data_val;

    // concatenate the enabled fields, msb first
    //   without a status field any fault swaps the data for the
    //   error code for as long as the fault lasts
    always @* begin
        body     = 32'h00000000;
        body_len = 6'h00;
        data_val = data_type_select ? MEAS_AUX : MEAS_MAIN;
        if (!stat_on && status_code != `PDDR_ST_NORMAL)
            data_val = ERR_CODE;
        if (periodic_frame_format[`PDDR_FMT_ID_BIT]) begin
            body     = {body[27:0], src_id};
            body_len = body_len + 6'd4;
        end
        if (periodic_frame_format[`PDDR_FMT_KAC_BIT]) begin
            body     = {body[29:0], kac_cur};
            body_len = body_len + 6'd2;
        end
        if (stat_on) begin
            body     = {body[27:0], status_code};
            body_len = body_len + 6'd4;
        end
        body     = (body << DATA_W) | {{(32-DATA_W){1'b0}}, data_val};
        body_len = body_len + DATA_W[5:0];
    end

    // periodic check value: seed of four zeros then source id
    //   the seed carries the slot's id even when the id field is
    //   off; eight zeros are shifted in after the message
    wire [7:0] frame_crc;
    pddr_crc8 #(
        .POLY (`PDDR_POLY)
    ) u_frame_crc (
        .seed ({4'h0, src_id}),
        .msg  (body),
        .len  (body_len),
        .crc  (frame_crc)
    );

    // response output and keep alive counters
    //   frame and length hold until the next frame, only the strobe
    //   pulses; a slot's counter steps after each of its frames and
    //   wraps from 3 to 0; enabled follows end of init a cycle late
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            RESP_STB          <= 1'b0;
            RESP_LEN          <= 6'h00;
            RESP_FRAME        <= 32'h00000000;
            keep_alive_count0 <= 2'h0;
            keep_alive_count1 <= 2'h0;
            ENABLED           <= 1'b0;
        end else begin
            ENABLED  <= end_of_init_flag;
            RESP_STB <= do_resp;
            if (do_resp) begin
                RESP_FRAME <= {body[23:0], frame_crc};
                RESP_LEN   <= body_len + 6'd8;
                if (CMD_SLOT)
                    keep_alive_count1 <= keep_alive_count1 + 2'h1;
                else
                    keep_alive_count0 <= keep_alive_count0 + 2'h1;
            end
        end
    end
endmodule // pddr_responder
`default_nettype wire

// file: inc/pddr_defines.vh
// constants for the periodic data and diagnostic responder
`ifndef PDDR_DEFINES_VH
`define PDDR_DEFINES_VH

// ==========================================================
// register byte offsets
`define PDDR_OFS_LOCK        12'h000
`define PDDR_OFS_TIMING2     12'h004
`define PDDR_OFS_SRC0        12'h008
`define PDDR_OFS_SRC1        12'h00C
`define PDDR_OFS_PHYS        12'h010
`define PDDR_OFS_STATUS      12'h014
`define PDDR_OFS_DIAGCMD     12'h018

// ==========================================================
// field positions
`define PDDR_LOCK_EOI_BIT    0
`define PDDR_TIM_DIAG_BIT    0
`define PDDR_TIM_FRAG_BIT    1
`define PDDR_SRC_ID_LSB      0
`define PDDR_SRC_FMT_LSB     4
`define PDDR_SRC_DTYPE_BIT   8
`define PDDR_FMT_ID_BIT      0
`define PDDR_FMT_KAC_BIT     1
`define PDDR_FMT_STAT_BIT    2

// ==========================================================
// reset values
`define PDDR_RST_TIMING2     2'h0
`define PDDR_RST_SRC         9'h000
`define PDDR_RST_PHYS        4'h0

// ==========================================================
// command lengths and frame sizes
`define PDDR_LEN_BCAST       6'h01
`define PDDR_LEN_FRAG2       6'h02
`define PDDR_LEN_FRAG4       6'h04
`define PDDR_DIAG_BITS       6'h20
`define PDDR_ID_W            4
`define PDDR_KAC_W           2
`define PDDR_STAT_W          4
`define PDDR_CRC_W           8

// ==========================================================
// check value and status codes
`define PDDR_POLY            8'h2F
`define PDDR_GLOBAL_ADDR     4'h0
`define PDDR_ST_NORMAL       4'h0
`define PDDR_ST_UNLOCKED     4'h1
`define PDDR_ST_SELFTEST     4'h2
`define PDDR_ST_OSC          4'h3
`define PDDR_ST_CLIP         4'h4
`define PDDR_ST_TEMP         4'h5

`endif

// file: rtl/pddr_crc8.v
// serial eight bit check value over a right aligned message
`timescale 1ns/1ps
`default_nettype none
module pddr_crc8 #(
    parameter [7:0] POLY = 8'h2F
) (
    input  wire [7:0]  seed,  // preset value
    input  wire [31:0] msg,   // message, last bit in bit 0
    input  wire [5:0]  len,   // message length in bits
    output reg  [7:0]  crc    // resulting check value
);
    integer i;
    reg     fb;

    // ==========================================================
    // shift message msb first, then eight zeros
    always @* begin
        crc = seed;
        fb  = 1'b0;
        for (i = 31; i >= 0; i = i - 1) begin
            if (i < len) begin
                fb  = crc[7];
                crc = {crc[6:0], msg[i]} ^ (fb ? POLY : 8'h00);
            end
        end
        for (i = 0; i < 8; i = i + 1) begin
            fb  = crc[7];
            crc = {crc[6:0], 1'b0} ^ (fb ? POLY : 8'h00);
        end
    end
endmodule // pddr_crc8
`default_nettype wire

// file: verification/pddr_responder_props.sv
// port checker for the periodic data and diagnostic responder
`timescale 1ns/1ps
`default_nettype none
module pddr_responder_props (
    input wire logic        CLOCK,     // core clock
    input wire logic        NRST,      // reset, active low
    input wire logic        PSEL,      // apb select
    input wire logic        PENABLE,   // apb access phase
    input wire logic        PREADY,    // apb done
    input wire logic        PSLVERR,   // apb error
    input wire logic        CMD_VALID, // command strobe
    input wire logic [5:0]  CMD_LEN,   // command length
    input wire logic        RESP_STB,  // frame strobe
    input wire logic [5:0]  RESP_LEN,  // frame length
    input wire logic        DIAG_STB,  // good command strobe
    input wire logic        DIAG_ERR,  // bad command strobe
    input wire logic [31:0] DIAG_WORD, // last command
    input wire logic        ENABLED    // periodic mode on
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    // ===========================================================
    // sequences
    sequence s_apb_wait; PSEL && PENABLE && !PREADY; endsequence
    sequence s_apb_done; PREADY ##1 !PREADY; endsequence
    sequence s_bcast; CMD_VALID && CMD_LEN == 6'h01 && ENABLED; endsequence
    // ===========================================================
    // properties
    property p_apb_one_wait; s_apb_wait |=> s_apb_done; endproperty
    property p_err_ready; PSLVERR |-> PREADY && $past(PSEL && PENABLE); endproperty
    property p_bcast_answered; s_bcast |=> RESP_STB; endproperty
    property p_resp_cause; RESP_STB |-> $past(CMD_VALID) && $past(CMD_LEN) inside {1, 2, 4};
    endproperty
    property p_bad_len_silent; CMD_VALID && !(CMD_LEN inside {1, 2, 4}) |=> !RESP_STB;
    endproperty
    property p_frame_len; RESP_STB |-> RESP_LEN inside {18, 20, 22, 24, 26, 28}; endproperty
    property p_diag_cause; DIAG_STB || DIAG_ERR |-> $past(CMD_LEN) inside {2, 4};
    endproperty
    property p_diag_excl; DIAG_STB |-> !DIAG_ERR; endproperty
    property p_word_update; $changed(DIAG_WORD) |-> DIAG_STB; endproperty
    property p_enabled_sticky; ENABLED |=> ENABLED [*3]; endproperty
    a_apb_one_wait: assert property (p_apb_one_wait) else $error("apb wait not one cycle");
    a_err_ready: assert property (p_err_ready) else $error("slave error outside access");
    a_bcast_answered: assert property (p_bcast_answered)
        else $error("broadcast read unanswered");
    a_resp_cause: assert property (p_resp_cause)
        else $error("frame without command");
    a_bad_len_silent: assert property (p_bad_len_silent)
        else $error("frame for bad length");
    a_frame_len: assert property (p_frame_len)
        else $error("frame length wrong");
    a_diag_cause: assert property (p_diag_cause)
        else $error("diag strobe without fragment");
    a_diag_excl: assert property (p_diag_excl)
        else $error("diag good and bad together");
    a_word_update: assert property (p_word_update)
        else $error("diag word changed silently");
    a_enabled_sticky: assert property (p_enabled_sticky)
        else $error("periodic mode dropped");
endmodule // pddr_responder_props
bind pddr_responder pddr_responder_props u_pddr_responder_props (.CLOCK, .NRST, .PSEL,
    .PENABLE, .PREADY, .PSLVERR, .CMD_VALID, .CMD_LEN, .RESP_STB, .RESP_LEN, .DIAG_STB,
    .DIAG_ERR, .DIAG_WORD, .ENABLED);
`default_nettype wire

// file: verification/pddr_bus_master.sv
// bus master model sending decoded commands to the responder
`timescale 1ns/1ps
`default_nettype none
module pddr_bus_master (
    input  wire logic        CLOCK,     // core clock
    output var  logic        CMD_VALID, // command strobe
    output var  logic [5:0]  CMD_LEN,   // command length
    output var  logic [31:0] CMD_BITS,  // command bits
    output var  logic        CMD_SLOT   // response slot
);
    // idle lines start quiet
    initial begin
        CMD_VALID = 1'b0;
        CMD_LEN = 6'h00;
        CMD_BITS = 32'h0;
        CMD_SLOT = 1'b0;
    end
    // one command, one cycle; released length and bits show inverted data so stale values never pass
    task automatic send(input logic [5:0] n, input logic [31:0] b, input logic s);
        @(posedge CLOCK);
        CMD_VALID <= 1'b1;
        CMD_LEN <= n;
        CMD_BITS <= b;
        CMD_SLOT <= s;
        @(posedge CLOCK);
        CMD_VALID <= 1'b0;
        CMD_LEN <= ~n;
        CMD_BITS <= ~b;
    endtask
endmodule // pddr_bus_master
`default_nettype wire

// file: verification/tb_pddr_responder.sv
// self-checking bench for the periodic data and diagnostic responder
`timescale 1ns/1ps
`default_nettype none
module tb_pddr_responder;
    logic        clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, resp_frame, diag_word, cmd_bits, rd, dc;
    logic        pready, pslverr, cmd_valid, cmd_slot, resp_stb, diag_stb, diag_err, enabled, er;
    logic [5:0]  cmd_len, resp_len;
    logic [9:0]  meas_main = 10'h1FF, meas_aux = 10'h1FE, e_d;
    logic [7:0]  flags = 8'h00;
    logic [3:0]  sid [2], e_st;
    logic [2:0]  fmt [2];
    logic [1:0]  keep_alive_count [2];
    int          mismatches = 0, compares = 0, cycles = 0;
    pddr_responder u_pddr_responder (.CLOCK(clock), .NRST(nrst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CMD_VALID(cmd_valid), .CMD_LEN(cmd_len),
        .CMD_BITS(cmd_bits), .CMD_SLOT(cmd_slot), .MEAS_MAIN(meas_main), .MEAS_AUX(meas_aux),
        .USER_UNLOCKED(flags[0]), .SELFTEST_INCOMPLETE(flags[1]), .SELFTEST_RUNNING(flags[2]),
        .SELFTEST_FAIL(flags[3]), .OSC_TRAIN_ERR(flags[4]), .SIGNAL_CLIPPED(flags[5]),
        .OFFSET_ERR(flags[6]), .TEMP_ERR(flags[7]), .RESP_STB(resp_stb), .RESP_LEN(resp_len),
        .RESP_FRAME(resp_frame), .DIAG_STB(diag_stb), .DIAG_ERR(diag_err),
        .DIAG_WORD(diag_word), .ENABLED(enabled));
    pddr_bus_master u_pddr_bus_master (.CLOCK(clock), .CMD_VALID(cmd_valid),
        .CMD_LEN(cmd_len), .CMD_BITS(cmd_bits), .CMD_SLOT(cmd_slot));
    // ===========================================================
    // clock and hang guard
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    // ===========================================================
    // helpers
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // augmented serial check value, message msb first then eight zeros
    function automatic logic [7:0] crc8(input logic [31:0] m, input int n, input logic [7:0] s);
        crc8 = s;
        for (int i = n + 7; i >= 0; i--)
            crc8 = {crc8[6:0], (i >= 8) ? m[i-8] : 1'b0} ^ (crc8[7] ? 8'h2F : 8'h00);
    endfunction
    // apb master: setup, access, hold until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg(input logic s, input logic [3:0] id, input logic [2:0] f, input logic t);
        apb(1'b1, 12'h008 + {9'h0, s, 2'h0}, {23'h0, t, 1'b0, f, id});
        sid[s] = id;
        fmt[s] = f;
    endtask
    task automatic setf(input logic [7:0] f);
        @(posedge clock);
        flags <= f;
    endtask
    // one command, then the frame expected from the mirrored settings
    task automatic cmd(input logic [5:0] n, input logic [31:0] b, input logic s, input logic r);
        logic [31:0] x;
        int          l;
        u_pddr_bus_master.send(n, b, s);
        #1;
        chk("resp_stb", {31'h0, resp_stb}, {31'h0, r});
        if (r) begin
            x = fmt[s][0] ? {28'h0, sid[s]} : 32'h0;
            x = fmt[s][1] ? {x[29:0], keep_alive_count[s]} : x;
            x = fmt[s][2] ? {x[27:0], e_st} : x;
            x = {x[21:0], e_d};
            l = 10 + (fmt[s][0] ? 4 : 0) + (fmt[s][1] ? 2 : 0) + (fmt[s][2] ? 4 : 0);
            chk("resp_frame", resp_frame, {x[23:0], crc8(x, l, {4'h0, sid[s]})});
            chk("resp_len", {26'h0, resp_len}, l + 8);
            keep_alive_count[s] = keep_alive_count[s] + 2'h1;
        end
    endtask
    // ===========================================================
    // tests
    initial begin
        keep_alive_count[0] = 2'h0;
        keep_alive_count[1] = 2'h0;
        e_st = 4'h0;
        e_d = 10'h1FF;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        cmd(6'h01, 32'h1, 1'b0, 1'b0);
        cfg(1'b0, 4'h1, 3'h7, 1'b0);
        cfg(1'b1, 4'h2, 3'h3, 1'b1);
        apb(1'b1, 12'h000, 32'h1);
        repeat (2) @(posedge clock);
        chk("enabled", {31'h0, enabled}, 32'h1);
        for (int i = 0; i < 5; i++)
            cmd(6'h01, i & 1, 1'b0, 1'b1);
        e_d = 10'h1FE;
        cmd(6'h01, 32'h0, 1'b1, 1'b1);
        cmd(6'h02, 32'h1, 1'b0, 1'b0);
        cmd(6'h04, 32'h5, 1'b0, 1'b0);
        e_d = 10'h1FF;
        for (int k = 0; k < 8; k++) begin
            setf(8'h01 << k);
            e_st = 4'(32'h5443_2221 >> (4 * k));
            cmd(6'h01, 32'h1, 1'b0, 1'b1);
        end
        setf(8'hFF);
        e_st = 4'h5;
        cmd(6'h01, 32'h0, 1'b0, 1'b1);
        apb(1'b0, 12'h014, 32'h0);
        chk("status", {28'h0, rd[3:0]}, 32'h5);
        cfg(1'b0, 4'h1, 3'h3, 1'b0);
        e_d = 10'h3FF;
        cmd(6'h01, 32'h1, 1'b0, 1'b1);
        setf(8'h00);
        e_d = 10'h1FF;
        apb(1'b1, 12'h004, 32'h1);
        cmd(6'h03, 32'h7, 1'b0, 1'b0);
        dc = {8'h0, 4'h0, 4'hA, 16'h1234};
        dc = {dc[23:0], crc8(dc, 24, 8'hFF)};
        for (int j = 0; j < 6; j++)
            cmd(6'h02, {30'h0, dc[31-2*j -: 2]}, 1'b0, 1'b1);
        cmd(6'h01, 32'h0, 1'b0, 1'b1);
        for (int j = 0; j < 16; j++) begin
            cmd(6'h02, {30'h0, dc[31-2*j -: 2]}, 1'b0, 1'b1);
            chk("diag_stb", {31'h0, diag_stb}, {31'h0, j == 15});
        end
        chk("diag_word", diag_word, dc);
        apb(1'b1, 12'h004, 32'h3);
        for (int j = 0; j < 8; j++) begin
            cmd(6'h04, {28'h0, dc[31-4*j -: 4] ^ {3'h0, j == 7}}, 1'b0, 1'b1);
            chk("diag_err", {31'h0, diag_err}, {31'h0, j == 7});
        end
        apb(1'b0, 12'h018, 32'h0);
        chk("diag_reg", rd, dc);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
        complete_run();
    end
endmodule // tb_pddr_responder
`default_nettype wire
